// ### pkg/cgs_pkg.sv
// constants for the clock generator smbus configuration block
// assumes the smbus wires are filtered in the core_clk domain before use
// Overview of operation
// - slave only, one 7-bit address plus direction
// - master may stop after any whole byte
// - address 11010, strap bit, then zero
// - write: offset, count, data bytes, all acknowledged
// - read: offset, repeated start, count, data, nack
// - per-output enable bit overrides pin when zero
// - disabled state field: low, hiz, low, high
// - spread readback bits latched from strap, read-only
// - select bit picks latched or software spread
// - software spread bits: off, 0.25, off, 0.5
// - per-output slew bit, one is fast
// - crystal output slew field powers up 01
// - wake bit keeps crystal output running powered down
// - crystal output enable bit powers up one
// - read count from byte count register, default eight
package cgs_pkg;
    localparam int        NUM_DIFF        = 6;
    // register offsets
    localparam logic [7:0] OFS_OUT_ENABLE = 8'h00;
    localparam logic [7:0] OFS_SPREAD_AMP = 8'h01;
    localparam logic [7:0] OFS_DIFF_SLEW  = 8'h02;
    localparam logic [7:0] OFS_XTAL_CTRL  = 8'h03;
    localparam logic [7:0] OFS_BYTE_COUNT = 8'h07;
    localparam logic [7:0] OFS_STOP_CTRL  = 8'h0B;
    // power-up values and writable-bit masks
    localparam logic [7:0] RST_OUT_ENABLE = 8'hDD;
    localparam logic [7:0] MSK_OUT_ENABLE = 8'hDD;
    localparam logic [5:0] RST_SPREAD_AMP = 6'h06;
    localparam logic [5:0] MSK_SPREAD_AMP = 6'h3B;
    localparam logic [7:0] RST_DIFF_SLEW  = 8'hFF;
    localparam logic [7:0] MSK_DIFF_SLEW  = 8'hDD;
    localparam logic [7:0] RST_XTAL_CTRL  = 8'h5F;
    localparam logic [7:0] MSK_XTAL_CTRL  = 8'hF0;
    localparam logic [7:0] RST_BYTE_COUNT = 8'h08;
    localparam logic [7:0] MSK_BYTE_COUNT = 8'h1F;
    localparam logic [7:0] RST_STOP_CTRL  = 8'h00;
    localparam logic [7:0] MSK_STOP_CTRL  = 8'h03;
    // field positions
    localparam int         DIFF_BIT [NUM_DIFF] = '{0, 2, 3, 4, 6, 7};
    localparam int         POS_SW_SELECT  = 5;
    localparam int         POS_SW_AMT     = 3;
    localparam int         POS_AMPLITUDE  = 0;
    localparam int         POS_XTAL_SLEW  = 6;
    localparam int         POS_XTAL_WAKE  = 5;
    localparam int         POS_XTAL_EN    = 4;
    // fixed address bits
    localparam logic [4:0] ADDR_FIXED_HI  = 5'h1A;
    localparam logic       ADDR_FIXED_LO  = 1'b0;

    typedef enum logic [6:0] {
        CGS_IDLE     = 7'h01,
        CGS_ADDR     = 7'h02,
        CGS_ADDR_ACK = 7'h04,
        CGS_RX       = 7'h08,
        CGS_RX_ACK   = 7'h10,
        CGS_TX       = 7'h20,
        CGS_TX_ACK   = 7'h40
    } cgs_state_e;
endpackage

// ### logic/cgs_pin_sync.sv
// three-flop synchroniser bank for pins entering the core_clk domain
// the filtered level changes only once the second and third flops agree
`timescale 1ns/1ns
module cgs_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // pins
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] rst_value,
    output logic      [WIDTH-1:0] level
);
    initial begin
        if (WIDTH < 1) $error("cgs_pin_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [1:0]       fill;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '1;
            fill   <= 2'h0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // idle level until the chain has filled, then filtered value
            if (fill != 2'h3) begin
                fill  <= fill + 2'h1;
                level <= rst_value;
            end else begin
                for (int i = 0; i < WIDTH; i++) begin
                    if (stage2[i] == stage3[i]) begin
                        level[i] <= stage3[i];
                    end
                end
            end
        end
    end
endmodule

// ### logic/cgs_smbus_regs.sv
// smbus slave and configuration bytes of a six-output clock generator
// scl, sda and the strap and enable pins arrive asynchronously
`timescale 1ns/1ns
module cgs_smbus_regs
    import cgs_pkg::*;
(
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    // smbus
    input  wire logic                     smb_scl_in,
    input  wire logic                     smb_sda_in,
    output logic                          smb_sda_out,
    output logic                          smb_sda_oe_n,
    // straps and enable pins
    input  wire logic                     address_strap_pin,
    input  wire logic [1:0]               spread_strap_level,
    input  wire logic [cgs_pkg::NUM_DIFF-1:0] diff_out_enable_pin_n,
    // controls to the analog stages
    output logic [cgs_pkg::NUM_DIFF-1:0]  diff_out_run,
    output logic [1:0]                    disabled_state_field,
    output logic [1:0]                    spread_amount,
    output logic [1:0]                    amplitude_select,
    output logic [cgs_pkg::NUM_DIFF-1:0]  diff_out_edge_fast,
    output logic [1:0]                    buffered_crystal_edge_speed,
    output logic                          buffered_crystal_powerdown_run,
    output logic                          buffered_crystal_out_enable
);
    typedef struct packed {
        cgs_state_e          state;
        logic                scl_prev;
        logic                sda_prev;
        logic                sda_drive;
        logic [7:0]          shreg;
        logic [2:0]          bit_cnt;
        logic                byte_done;
        logic                acked;
        logic                reading;
        logic [1:0]          rx_idx;
        logic [7:0]          ptr;
        logic [7:0]          remaining;
        logic                latched;
        logic [2:0]          settle;
        logic                addr_strap;
        logic [1:0]          spread_latch;
        logic [7:0]          out_enable;
        logic [5:0]          spread_amp;
        logic [7:0]          diff_slew;
        logic [7:0]          xtal_ctrl;
        logic [7:0]          byte_count;
        logic [7:0]          stop_ctrl;
        logic [NUM_DIFF-1:0] run;
        logic [1:0]          amount;
    } cgs_regs_s;

    localparam int SYNC_W = NUM_DIFF + 5;

    cgs_regs_s        r;
    cgs_regs_s        next_r;
    logic [1:0]       rst_pipe;
    logic             rst_n;
    logic [SYNC_W-1:0] pin_level;
    logic             scl;
    logic             sda;
    logic             strap_addr;
    logic [1:0]       strap_spread;
    logic [NUM_DIFF-1:0] pin_en_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    cgs_pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    ({smb_scl_in, smb_sda_in, address_strap_pin,
                     spread_strap_level, diff_out_enable_pin_n}),
        .rst_value ({2'h3, 3'h0, {NUM_DIFF{1'b1}}}),
        .level     (pin_level)
    );
    assign {scl, sda, strap_addr, strap_spread, pin_en_n} = pin_level;

    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic logic [7:0] reg_read(input cgs_regs_s s, input logic [7:0] ofs);
        unique case (ofs)
            OFS_OUT_ENABLE: reg_read = s.out_enable;
            OFS_SPREAD_AMP: reg_read = {s.spread_latch, s.spread_amp};
            OFS_DIFF_SLEW:  reg_read = s.diff_slew;
            OFS_XTAL_CTRL:  reg_read = s.xtal_ctrl;
            OFS_BYTE_COUNT: reg_read = s.byte_count;
            OFS_STOP_CTRL:  reg_read = s.stop_ctrl;
            default:        reg_read = 8'h00;
        endcase
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise   = scl & ~r.scl_prev;
    assign scl_fall   = ~scl & r.scl_prev;
    assign start_seen = scl & r.scl_prev & r.sda_prev & ~sda;
    assign stop_seen  = scl & r.scl_prev & ~r.sda_prev & sda;

    always_comb begin
        logic [7:0] tx_byte;
        tx_byte  = 8'h00;
        next_r   = r;
        next_r.scl_prev = scl;
        next_r.sda_prev = sda;

        // straps follow the filtered pins until the filter has surely settled
        if (!r.latched) begin
            next_r.settle       = r.settle + 3'h1;
            next_r.latched      = (r.settle == 3'h7);
            next_r.addr_strap   = strap_addr;
            next_r.spread_latch = strap_spread;
        end

        if (stop_seen) begin
            // early stop keeps every byte already taken
            next_r.state     = CGS_IDLE;
            next_r.sda_drive = 1'b0;
        end else if (start_seen) begin
            // repeated start keeps the offset for the read
            next_r.state     = CGS_ADDR;
            next_r.sda_drive = 1'b0;
            next_r.bit_cnt   = 3'h0;
            next_r.byte_done = 1'b0;
        end else begin
            unique case (r.state)
                CGS_IDLE: begin
                    next_r.sda_drive = 1'b0;
                end
                CGS_ADDR, CGS_RX: begin
                    if (scl_rise) begin
                        next_r.shreg     = {r.shreg[6:0], sda};
                        next_r.bit_cnt   = r.bit_cnt + 3'h1;
                        next_r.byte_done = (r.bit_cnt == 3'h7);
                    end else if (scl_fall && r.byte_done) begin
                        next_r.byte_done = 1'b0;
                        if (r.state == CGS_ADDR) begin
                            if (r.shreg[7:1] == {ADDR_FIXED_HI, r.addr_strap,
                                                 ADDR_FIXED_LO}) begin
                                next_r.sda_drive = 1'b1;
                                next_r.reading   = r.shreg[0];
                                next_r.state     = CGS_ADDR_ACK;
                            end else begin
                                next_r.state = CGS_IDLE;
                            end
                        end else begin
                            next_r.sda_drive = 1'b1;
                            next_r.state     = CGS_RX_ACK;
                            unique case (r.rx_idx)
                                2'h0: begin
                                    next_r.ptr    = r.shreg;
                                    next_r.rx_idx = 2'h1;
                                end
                                2'h1: begin
                                    next_r.remaining = r.shreg;
                                    next_r.rx_idx    = 2'h2;
                                end
                                default: begin
                                    if (r.remaining != 8'h00) begin
                                        next_r.remaining = r.remaining - 8'h01;
                                        next_r.ptr       = r.ptr + 8'h01;
                                        unique case (r.ptr)
                                            OFS_OUT_ENABLE: next_r.out_enable =
                                                merge(r.out_enable, r.shreg, MSK_OUT_ENABLE);
                                            OFS_SPREAD_AMP: next_r.spread_amp =
                                                6'(merge({2'h0, r.spread_amp}, r.shreg,
                                                         {2'h0, MSK_SPREAD_AMP}));
                                            OFS_DIFF_SLEW:  next_r.diff_slew =
                                                merge(r.diff_slew, r.shreg, MSK_DIFF_SLEW);
                                            OFS_XTAL_CTRL:  next_r.xtal_ctrl =
                                                merge(r.xtal_ctrl, r.shreg, MSK_XTAL_CTRL);
                                            OFS_BYTE_COUNT: next_r.byte_count =
                                                merge(r.byte_count, r.shreg, MSK_BYTE_COUNT);
                                            OFS_STOP_CTRL:  next_r.stop_ctrl =
                                                merge(r.stop_ctrl, r.shreg, MSK_STOP_CTRL);
                                            default: ;
                                        endcase
                                    end
                                end
                            endcase
                        end
                    end
                end
                CGS_ADDR_ACK, CGS_RX_ACK: begin
                    if (scl_fall) begin
                        next_r.bit_cnt = 3'h0;
                        if (r.state == CGS_ADDR_ACK && r.reading) begin
                            // first byte of a read is the count
                            tx_byte          = r.byte_count;
                            next_r.rx_idx    = 2'h1;
                            next_r.shreg     = tx_byte;
                            next_r.sda_drive = ~tx_byte[7];
                            next_r.state     = CGS_TX;
                        end else begin
                            if (r.state == CGS_ADDR_ACK) begin
                                next_r.rx_idx = 2'h0;
                            end
                            next_r.sda_drive = 1'b0;
                            next_r.state     = CGS_RX;
                        end
                    end
                end
                CGS_TX: begin
                    if (scl_rise) begin
                        next_r.bit_cnt   = r.bit_cnt + 3'h1;
                        next_r.byte_done = (r.bit_cnt == 3'h7);
                    end else if (scl_fall) begin
                        if (r.byte_done) begin
                            next_r.byte_done = 1'b0;
                            next_r.sda_drive = 1'b0;
                            next_r.acked     = 1'b0;
                            next_r.state     = CGS_TX_ACK;
                        end else begin
                            next_r.shreg     = {r.shreg[6:0], 1'b0};
                            next_r.sda_drive = ~r.shreg[6];
                        end
                    end
                end
                CGS_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda) begin
                            next_r.state = CGS_IDLE;
                        end else begin
                            next_r.acked = 1'b1;
                        end
                    end else if (scl_fall && r.acked) begin
                        tx_byte          = reg_read(r, r.ptr);
                        next_r.ptr       = r.ptr + 8'h01;
                        next_r.shreg     = tx_byte;
                        next_r.sda_drive = ~tx_byte[7];
                        next_r.bit_cnt   = 3'h0;
                        next_r.state     = CGS_TX;
                    end
                end
            endcase
        end

        // outputs follow the pin only while the enable bit is one
        for (int i = 0; i < NUM_DIFF; i++) begin
            next_r.run[i] = r.out_enable[DIFF_BIT[i]] & ~pin_en_n[i];
        end
        // software amount applies only while the select bit is one
        next_r.amount = r.spread_amp[POS_SW_SELECT] ?
                        r.spread_amp[POS_SW_AMT +: 2] : r.spread_latch;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r              <= '0;
            r.state        <= CGS_IDLE;
            r.scl_prev     <= 1'b1;
            r.sda_prev     <= 1'b1;
            r.out_enable   <= RST_OUT_ENABLE;
            r.spread_amp   <= RST_SPREAD_AMP;
            r.diff_slew    <= RST_DIFF_SLEW;
            r.xtal_ctrl    <= RST_XTAL_CTRL;
            r.byte_count   <= RST_BYTE_COUNT;
            r.stop_ctrl    <= RST_STOP_CTRL;
        end else begin
            r <= next_r;
        end
    end

    assign smb_sda_out  = 1'b0;
    assign smb_sda_oe_n = ~r.sda_drive;
    assign diff_out_run = r.run;
    assign disabled_state_field = r.stop_ctrl[1:0];
    assign spread_amount    = r.amount;
    assign amplitude_select = r.spread_amp[POS_AMPLITUDE +: 2];
    always_comb begin
        for (int i = 0; i < NUM_DIFF; i++) begin
            diff_out_edge_fast[i] = r.diff_slew[DIFF_BIT[i]];
        end
    end
    assign buffered_crystal_edge_speed    = r.xtal_ctrl[POS_XTAL_SLEW +: 2];
    assign buffered_crystal_powerdown_run = r.xtal_ctrl[POS_XTAL_WAKE];
    assign buffered_crystal_out_enable    = r.xtal_ctrl[POS_XTAL_EN];
endmodule

// ### tb/cgs_smbus_regs_properties.sv
// checker for the smbus configuration block, watching its top ports only
// assumes scl high and low phases of at least 8 core_clk cycles
`timescale 1ns/1ns
module cgs_regs_checker
    import cgs_pkg::*;
(
    // clock and reset
    input wire logic                         core_clk,
    input wire logic                         resetn,
    // smbus
    input wire logic                         smb_scl_in,
    input wire logic                         smb_sda_out,
    input wire logic                         smb_sda_oe_n,
    // pins and controls
    input wire logic [cgs_pkg::NUM_DIFF-1:0] diff_out_enable_pin_n,
    input wire logic [cgs_pkg::NUM_DIFF-1:0] diff_out_run,
    input wire logic [1:0]                   disabled_state_field,
    input wire logic [1:0]                   amplitude_select,
    input wire logic [cgs_pkg::NUM_DIFF-1:0] diff_out_edge_fast,
    input wire logic [1:0]                   buffered_crystal_edge_speed,
    input wire logic                         buffered_crystal_powerdown_run,
    input wire logic                         buffered_crystal_out_enable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_sda_open_drain: assert property (smb_sda_out == 1'b0)
        else $error("sda output level not zero");
    a_pin_forces_off: assert property ((&diff_out_enable_pin_n)[*8] |-> diff_out_run == '0)
        else $error("output runs with its enable pin high");
    a_ack_scl_low: assert property ($fell(smb_sda_oe_n) |-> !smb_scl_in)
        else $error("sda pulled while scl high");
    a_release_scl_low: assert property ($rose(smb_sda_oe_n) |-> !smb_scl_in)
        else $error("sda released while scl high");
    a_drive_held_high: assert property (!smb_sda_oe_n && smb_scl_in |=> !smb_sda_oe_n || !smb_scl_in)
        else $error("driven sda bit dropped during scl high");
    a_amp_on_ack: assert property ($changed(amplitude_select) |-> !smb_sda_oe_n && !smb_scl_in)
        else $error("amplitude changed outside a write ack");
    a_slew_on_ack: assert property ($changed(diff_out_edge_fast) |-> !smb_sda_oe_n && !smb_scl_in)
        else $error("edge speed changed outside a write ack");
    a_xtal_on_ack: assert property ($changed({buffered_crystal_edge_speed, buffered_crystal_powerdown_run, buffered_crystal_out_enable}) |-> !smb_sda_oe_n)
        else $error("crystal control changed outside a write ack");
    a_stop_on_ack: assert property ($changed(disabled_state_field) |-> !smb_sda_oe_n && !smb_scl_in)
        else $error("disabled state changed outside a write ack");
endmodule

bind cgs_smbus_regs cgs_regs_checker cgs_regs_checker_inst (
    .core_clk, .resetn, .smb_scl_in, .smb_sda_out, .smb_sda_oe_n, .diff_out_enable_pin_n,
    .diff_out_run, .disabled_state_field, .amplitude_select, .diff_out_edge_fast,
    .buffered_crystal_edge_speed, .buffered_crystal_powerdown_run,
    .buffered_crystal_out_enable
);

// ### tb/cgs_host_model.sv
// smbus host model driving scl and an open-drain pull on sda
// assumes the bench resolves the sda wire with a pull-up
`timescale 1ns/1ns
module cgs_host_model (
    // clock
    input wire logic core_clk,
    // smbus wires
    input wire logic sda_wire,
    output logic     scl,
    output logic     sda_pull_low
);
    localparam int HALF = 10;
    initial begin
        scl = 1'b1;
        sda_pull_low = 1'b0;
    end
    // one scl period; sda moves only well after scl fell
    task automatic cycle(input logic pull, output logic seen);
        repeat (2) @(negedge core_clk);
        sda_pull_low = pull;
        repeat (HALF) @(negedge core_clk);
        scl = 1'b1;
        repeat (HALF / 2) @(negedge core_clk);
        seen = sda_wire;
        repeat (HALF / 2) @(negedge core_clk);
        scl = 1'b0;
    endtask
    // start and repeated start
    task automatic start();
        repeat (2) @(negedge core_clk);
        sda_pull_low = 1'b0;
        repeat (HALF) @(negedge core_clk);
        scl = 1'b1;
        repeat (HALF) @(negedge core_clk);
        sda_pull_low = 1'b1;
        repeat (HALF) @(negedge core_clk);
        scl = 1'b0;
    endtask
    task automatic stop();
        repeat (2) @(negedge core_clk);
        sda_pull_low = 1'b1;
        repeat (HALF) @(negedge core_clk);
        scl = 1'b1;
        repeat (HALF) @(negedge core_clk);
        sda_pull_low = 1'b0;
        repeat (HALF) @(negedge core_clk);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            cycle(~b[i], s);
        cycle(1'b0, s);
        ack = ~s;
    endtask
    task automatic get(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            cycle(1'b0, s);
            b[i] = s;
        end
        cycle(~last, s);
    endtask
endmodule

// ### tb/test_smbus_clockgen_config_regs.sv
// self-checking bench comparing the smbus configuration block with a byte model
// assumes the host model and the checker are compiled before this file
`timescale 1ns/1ns
module test_smbus_clockgen_config_regs;
    import cgs_pkg::*;
    logic       core_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       smb_scl_in;
    logic       host_low;
    logic       smb_sda_out;
    logic       smb_sda_oe_n;
    logic       address_strap_pin = 1'b0;
    logic [1:0] spread_strap_level = 2'h0;
    logic [5:0] diff_out_enable_pin_n = 6'h00;
    logic [5:0] diff_out_run;
    logic [1:0] disabled_state_field;
    logic [1:0] spread_amount;
    logic [1:0] amplitude_select;
    logic [5:0] diff_out_edge_fast;
    logic [1:0] buffered_crystal_edge_speed;
    logic       buffered_crystal_powerdown_run;
    logic       buffered_crystal_out_enable;
    wire        sda_wire = ~(host_low | ~smb_sda_oe_n & ~smb_sda_out);
    int         n_fail = 0;
    int         checked = 0;
    int         seed = 64;
    logic [7:0] mem [16];
    always #5 core_clk = ~core_clk;
    cgs_smbus_regs cgs_smbus_regs_inst (.core_clk, .resetn, .smb_scl_in,
        .smb_sda_in(sda_wire), .smb_sda_out, .smb_sda_oe_n, .address_strap_pin,
        .spread_strap_level, .diff_out_enable_pin_n, .diff_out_run, .disabled_state_field,
        .spread_amount, .amplitude_select, .diff_out_edge_fast, .buffered_crystal_edge_speed,
        .buffered_crystal_powerdown_run, .buffered_crystal_out_enable);
    cgs_host_model cgs_host_model_inst (.core_clk, .sda_wire, .scl(smb_scl_in),
        .sda_pull_low(host_low));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [7:0] wmask(input logic [7:0] o);
        case (o)
            OFS_OUT_ENABLE: return MSK_OUT_ENABLE;
            OFS_SPREAD_AMP: return {2'h0, MSK_SPREAD_AMP};
            OFS_DIFF_SLEW:  return MSK_DIFF_SLEW;
            OFS_XTAL_CTRL:  return MSK_XTAL_CTRL;
            OFS_BYTE_COUNT: return MSK_BYTE_COUNT;
            OFS_STOP_CTRL:  return MSK_STOP_CTRL;
            default:        return 8'h00;
        endcase
    endfunction
    task automatic do_reset(input logic a, input logic [1:0] s);
        resetn = 1'b0;
        address_strap_pin = a;
        spread_strap_level = s;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        repeat (12) @(negedge core_clk);
        foreach (mem[i])
            mem[i] = 8'h00;
        mem[OFS_OUT_ENABLE] = RST_OUT_ENABLE;
        mem[OFS_SPREAD_AMP] = {s, RST_SPREAD_AMP};
        mem[OFS_DIFF_SLEW] = RST_DIFF_SLEW;
        mem[OFS_XTAL_CTRL] = RST_XTAL_CTRL;
        mem[OFS_BYTE_COUNT] = RST_BYTE_COUNT;
        mem[OFS_STOP_CTRL] = RST_STOP_CTRL;
    endtask
    task automatic chk_outs();
        logic [5:0] r;
        logic [5:0] f;
        repeat (8) @(negedge core_clk);
        for (int i = 0; i < NUM_DIFF; i++) begin
            r[i] = mem[0][DIFF_BIT[i]] & ~diff_out_enable_pin_n[i];
            f[i] = mem[2][DIFF_BIT[i]];
        end
        chk("run", {2'h0, diff_out_run}, {2'h0, r});
        chk("edge", {2'h0, diff_out_edge_fast}, {2'h0, f});
        chk("spread", {6'h00, spread_amount}, {6'h00, mem[1][5] ? mem[1][4:3] : mem[1][7:6]});
        chk("amplitude", {6'h00, amplitude_select}, {6'h00, mem[1][1:0]});
        chk("crystal", {buffered_crystal_edge_speed, buffered_crystal_powerdown_run,
            buffered_crystal_out_enable, 4'h0}, {mem[3][7:4], 4'h0});
        chk("disabled", {6'h00, disabled_state_field}, {6'h00, mem[11][1:0]});
    endtask
    task automatic xfer_ack(input logic [7:0] b, input logic [7:0] exp);
        logic ack;
        cgs_host_model_inst.put(b, ack);
        chk("ack", {7'h00, ack}, exp);
    endtask
    task automatic hdr(input logic [7:0] n);
        cgs_host_model_inst.start();
        xfer_ack({ADDR_FIXED_HI, address_strap_pin, ADDR_FIXED_LO, 1'b0}, 8'h01);
        xfer_ack(n, 8'h01);
    endtask
    task automatic wr(input logic [7:0] n, input int x, input int sent);
        logic [7:0] d;
        hdr(n);
        xfer_ack(8'(x), 8'h01);
        for (int i = 0; i < sent; i++) begin
            d = 8'($random(seed));
            if (8'(n + i) == OFS_SPREAD_AMP)
                d[3] = mem[OFS_SPREAD_AMP][6]; // keep strap on/off, change amount
            xfer_ack(d, 8'h01);
            if (i < x)
                mem[n + i] = mem[n + i] & ~wmask(8'(n + i)) | d & wmask(8'(n + i));
        end
        cgs_host_model_inst.stop();
        chk_outs();
    endtask
    task automatic rd(input logic [7:0] n, input int k);
        logic [7:0] b;
        hdr(n);
        cgs_host_model_inst.start();
        xfer_ack({ADDR_FIXED_HI, address_strap_pin, ADDR_FIXED_LO, 1'b1}, 8'h01);
        cgs_host_model_inst.get(k == 0, b);
        chk("count byte", b, mem[OFS_BYTE_COUNT]);
        for (int i = 0; i < k; i++) begin
            cgs_host_model_inst.get(i == k - 1, b);
            chk("read data", b, mem[n + i]);
        end
        cgs_host_model_inst.stop();
    endtask
    initial begin
        logic [1:0] straps [3] = '{2'h0, 2'h2, 2'h3};
        int         x;
        int         k;
        for (int r = 0; r < 2; r++) begin
            do_reset(r[0], straps[$unsigned($random(seed)) % 3]);
            chk_outs();
            rd(8'h00, 8);
            cgs_host_model_inst.start();
            xfer_ack({ADDR_FIXED_HI, ~address_strap_pin, ADDR_FIXED_LO, 1'b0}, 8'h00);
            cgs_host_model_inst.start();
            xfer_ack({ADDR_FIXED_HI, address_strap_pin, 1'b1, 1'b0}, 8'h00);
            cgs_host_model_inst.stop();
            wr(OFS_BYTE_COUNT, 1, 1);
            wr(OFS_STOP_CTRL, 1, 1);
            for (int j = 0; j < 6; j++) begin
                diff_out_enable_pin_n = (j == 0) ? 6'h3F : 6'($random(seed));
                x = 1 + $unsigned($random(seed)) % 3;
                wr(8'($unsigned($random(seed)) % 4), x, x - 1 + $unsigned($random(seed)) % 3);
                k = 1 + $unsigned($random(seed)) % 4;
                rd(8'($unsigned($random(seed)) % 12), (k < mem[7]) ? k : int'(mem[7]));
            end
        end
        wrap_up();
    end
    initial begin
        #900000;
        n_fail++;
        wrap_up();
    end
endmodule
